// ===== core/two_wire_pkg.sv
// Shared constants and types for the two-wire register link.
package two_wire_pkg;
  localparam logic [4:0] CHIP_PREFIX = 5'h02;
  localparam logic [7:0] REG_ADDR = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] ACK_DONE = 4'h9;
  localparam logic [3:0] BIT_STEP = 4'h1;
  localparam int LIVE_BITS = 5;
  localparam int FAULT_BITS = 3;
  localparam int CLK_HZ = 250000000;
  localparam int SCL_HZ = 100000;
  localparam int QTR_CYCLES = (CLK_HZ + 4 * SCL_HZ - 1) / (4 * SCL_HZ);
  localparam logic [1:0] OFS_CMD = 2'h0;
  localparam logic [1:0] OFS_WDATA = 2'h1;
  localparam logic [1:0] OFS_STAT = 2'h2;
  localparam logic [1:0] OFS_RDATA = 2'h3;
  localparam int CMD_WR_BIT = 8;
  localparam int CMD_RD_BIT = 9;
  localparam int STAT_NACK_BIT = 1;
  localparam logic [2:0] WR_LAST = 3'h4;
  localparam logic [2:0] RD_LAST = 3'h7;
  localparam logic [2:0] BIT_TOP = 3'h7;
  typedef enum logic [2:0] {
    st_idle = 3'h0,
    st_chip = 3'h1,
    st_reg = 3'h3,
    st_data = 3'h2,
    st_send = 3'h6,
    st_ignore = 3'h7
  } dev_state_t;
  typedef enum logic [1:0] {
    step_start = 2'h0,
    step_tx = 2'h1,
    step_rx = 2'h3,
    step_stop = 2'h2
  } step_t;
  typedef enum logic {
    host_idle = 1'b0,
    host_busy = 1'b1
  } host_state_t;
endpackage : two_wire_pkg

// ===== core/two_wire_if.sv
// Open-drain wiring between the bus master and the register slave.
`timescale 1ns/1ps
interface two_wire_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic dev_irq_o;
  logic dev_irq_oe;
  logic scl;
  logic sda;
  logic irq_n;
  // Pull-ups win unless some enabled driver pulls low.
  assign scl = !(host_scl_oe && !host_scl_o);
  assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));
  assign irq_n = !(dev_irq_oe && !dev_irq_o);
  modport device (
    input scl,
    input sda,
    output dev_sda_o,
    output dev_sda_oe,
    output dev_irq_o,
    output dev_irq_oe
  );
  modport host (
    input scl,
    input sda,
    input irq_n,
    output host_scl_o,
    output host_scl_oe,
    output host_sda_o,
    output host_sda_oe
  );
endinterface : two_wire_if

// ===== core/two_wire_bus_master.sv
// Bus master end: Avalon-MM command registers driving the two-wire link.
`timescale 1ns/1ps
module two_wire_bus_master #(
  parameter int QTR_CYCLES = two_wire_pkg::QTR_CYCLES
) (
  input wire logic ref_clk,
  input wire logic reset,
  two_wire_if.host bus,
  input wire logic [1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  // Write: start, chip/w, register, data, stop.
  // Read: start, chip/w, register, stop, start, chip/r, status, stop.
  function automatic two_wire_pkg::step_t step_kind(input logic rd, input logic [2:0] idx);
    step_kind = two_wire_pkg::step_tx;
    if (idx == 3'h0 || (rd && idx == 3'h4)) begin
      step_kind = two_wire_pkg::step_start;
    end else if (idx == (rd ? two_wire_pkg::RD_LAST : two_wire_pkg::WR_LAST)
                 || (rd && idx == 3'h3)) begin
      step_kind = two_wire_pkg::step_stop;
    end else if (rd && idx == 3'h6) begin
      step_kind = two_wire_pkg::step_rx;
    end
  endfunction : step_kind

  function automatic logic [7:0] step_byte(input logic rd, input logic [2:0] idx,
                                           input logic [1:0] sel, input logic [7:0] wd);
    step_byte = two_wire_pkg::REG_ADDR;
    if (idx == 3'h1) begin
      step_byte = {two_wire_pkg::CHIP_PREFIX, sel, 1'b0};
    end else if (idx == 3'h5) begin
      step_byte = {two_wire_pkg::CHIP_PREFIX, sel, 1'b1};
    end else if (!rd && idx == 3'h3) begin
      step_byte = wd;
    end
  endfunction : step_byte

  two_wire_pkg::host_state_t state;
  logic op_rd;
  logic [2:0] step;
  logic [1:0] qtr;
  logic [3:0] bitn;
  logic [15:0] div;
  logic tick;
  logic [1:0] target_sel;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic nack;
  logic sda_meta;
  logic sda_s;
  logic irq_meta;
  logic irq_s;
  logic scl_oe;
  logic sda_oe;

  wire req = avs_read | avs_write;
  wire take_wr = avs_write & !avs_waitrequest;
  wire busy = state == two_wire_pkg::host_busy;
  wire start_wr = take_wr && avs_address == two_wire_pkg::OFS_CMD
                  && !busy && avs_writedata[two_wire_pkg::CMD_WR_BIT];
  wire start_rd = take_wr && avs_address == two_wire_pkg::OFS_CMD
                  && !busy && avs_writedata[two_wire_pkg::CMD_RD_BIT];
  wire nack_clr = take_wr && avs_address == two_wire_pkg::OFS_STAT
                  && avs_writedata[two_wire_pkg::STAT_NACK_BIT];
  wire [31:0] rd_mux = (avs_address == two_wire_pkg::OFS_CMD) ? {30'h0, target_sel} :
                       (avs_address == two_wire_pkg::OFS_WDATA) ? {24'h0, wdata} :
                       (avs_address == two_wire_pkg::OFS_STAT) ? {29'h0, irq_s, nack, busy} :
                       {24'h0, rdata};
  wire two_wire_pkg::step_t kind = step_kind(op_rd, step);
  wire [7:0] cur_byte = step_byte(op_rd, step, target_sel, wdata);
  wire bit_end = bitn == two_wire_pkg::BITS_PER_BYTE;
  wire [2:0] bit_sel = two_wire_pkg::BIT_TOP - bitn[2:0];
  wire is_byte = kind == two_wire_pkg::step_tx || kind == two_wire_pkg::step_rx;
  wire last = step == (op_rd ? two_wire_pkg::RD_LAST : two_wire_pkg::WR_LAST);
  wire run = busy & tick;
  wire nack_set = run && qtr == 2'h2 && kind == two_wire_pkg::step_tx && bit_end && sda_s;

  assign bus.host_scl_o = 1'b0;
  assign bus.host_sda_o = 1'b0;
  assign bus.host_scl_oe = scl_oe;
  assign bus.host_sda_oe = sda_oe;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
    end else begin
      // One wait cycle per access, then the answer stands for one edge.
      avs_waitrequest <= !(req & avs_waitrequest);
      if (avs_read & avs_waitrequest) begin
        avs_readdata <= rd_mux;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      target_sel <= 2'h0;
      wdata <= 8'h0;
    end else if (take_wr && avs_address == two_wire_pkg::OFS_CMD) begin
      target_sel <= avs_writedata[1:0];
    end else if (take_wr && avs_address == two_wire_pkg::OFS_WDATA) begin
      wdata <= avs_writedata[7:0];
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      nack <= 1'b0;
    end else begin
      nack <= (nack & !nack_clr) | nack_set;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sda_meta <= 1'b1;
      sda_s <= 1'b1;
      irq_meta <= 1'b0;
      irq_s <= 1'b0;
    end else begin
      sda_meta <= bus.sda;
      sda_s <= sda_meta;
      irq_meta <= !bus.irq_n;
      irq_s <= irq_meta;
    end
  end

  // Quarter-bit enable; the clock line is made from it, never stretched.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      div <= 16'h0;
      tick <= 1'b0;
    end else begin
      tick <= div == 16'(QTR_CYCLES - 1);
      div <= (div == 16'(QTR_CYCLES - 1)) ? 16'h0 : div + 16'h1;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state <= two_wire_pkg::host_idle;
      op_rd <= 1'b0;
      step <= 3'h0;
      qtr <= 2'h0;
      bitn <= 4'h0;
      rdata <= 8'h0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end else if (!busy) begin
      if (start_wr | start_rd) begin
        state <= two_wire_pkg::host_busy;
        op_rd <= start_rd;
        step <= 3'h0;
        qtr <= 2'h0;
        bitn <= 4'h0;
      end
    end else if (run) begin
      qtr <= qtr + 2'h1;
      case (qtr)
        2'h0: begin
          case (kind)
            two_wire_pkg::step_start: sda_oe <= 1'b0;
            two_wire_pkg::step_stop: sda_oe <= 1'b1;
            two_wire_pkg::step_tx: sda_oe <= bit_end ? 1'b0 : !cur_byte[bit_sel];
            default: sda_oe <= bit_end;
          endcase
        end
        2'h1: scl_oe <= 1'b0;
        2'h2: begin
          if (kind == two_wire_pkg::step_start) begin
            sda_oe <= 1'b1;
          end else if (kind == two_wire_pkg::step_stop) begin
            sda_oe <= 1'b0;
          end else if (kind == two_wire_pkg::step_rx && !bit_end) begin
            rdata <= {rdata[6:0], sda_s};
          end
        end
        default: begin
          if (kind != two_wire_pkg::step_stop) begin
            scl_oe <= 1'b1;
          end
          if (is_byte && !bit_end) begin
            bitn <= bitn + two_wire_pkg::BIT_STEP;
          end else begin
            bitn <= 4'h0;
            if (last) begin
              state <= two_wire_pkg::host_idle;
            end else begin
              step <= step + 3'h1;
            end
          end
        end
      endcase
    end
  end
endmodule : two_wire_bus_master

// ===== core/serial_two_wire_register_slave.sv
// Device end: two-wire slave holding the control and fault status registers.
`timescale 1ns/1ps
module serial_two_wire_register_slave (
  input wire logic ref_clk,
  input wire logic reset,
  two_wire_if.device bus,
  input wire logic [1:0] addr_sel,
  input wire logic supply_low_fault,
  input wire logic overload_fault,
  input wire logic overtemp_fault,
  input wire logic [two_wire_pkg::LIVE_BITS-1:0] stat_live,
  output logic [7:0] control_settings,
  output logic ctrl_written
);
  two_wire_pkg::dev_state_t state;
  logic [3:0] bit_cnt;
  logic [7:0] shift;
  logic [7:0] tx;
  logic acked;
  logic sda_oe;
  logic irq_oe;
  logic [two_wire_pkg::FAULT_BITS-1:0] faults;
  logic scl_meta;
  logic scl_s;
  logic scl_p;
  logic sda_meta;
  logic sda_s;
  logic sda_p;
  logic [1:0] sel_meta;
  logic [1:0] sel_s;
  logic [two_wire_pkg::FAULT_BITS-1:0] fault_meta;
  logic [two_wire_pkg::FAULT_BITS-1:0] fault_s;

  // Both shift registers move one place per received clock except the acknowledge clock, newest bit last.
  function automatic logic [7:0] shift_in(input logic [7:0] v, input logic b);
    shift_in = {v[6:0], b};
  endfunction : shift_in

  // The line is only ever pulled, so a zero bit means enabling the driver.
  function automatic logic pull_for(input logic b);
    pull_for = !b;
  endfunction : pull_for

  wire scl_rise = scl_s & !scl_p;
  wire scl_fall = !scl_s & scl_p;
  // Both clock samples high, so a data edge here cannot be a data bit.
  wire start_seen = scl_s & scl_p & !sda_s & sda_p;
  wire stop_seen = scl_s & scl_p & sda_s & !sda_p;
  wire [6:0] own_addr = {two_wire_pkg::CHIP_PREFIX, sel_s};
  wire addr_match = shift[7:1] == own_addr;
  wire reg_ok = shift == two_wire_pkg::REG_ADDR;
  wire byte_in = bit_cnt == two_wire_pkg::BITS_PER_BYTE;
  wire ack_end = bit_cnt == two_wire_pkg::ACK_DONE;
  wire in_send = state == two_wire_pkg::st_send;
  // Only the address, register and data bytes of a frame can earn an acknowledge.
  wire want_ack = (state == two_wire_pkg::st_chip && addr_match)
                  || (state == two_wire_pkg::st_reg && reg_ok)
                  || state == two_wire_pkg::st_data;
  wire master_ack = in_send & scl_rise & byte_in & !sda_s;
  // Fault detectors run off their own timing, so they are synchronised first.
  wire [two_wire_pkg::FAULT_BITS-1:0] fault_pins =
      {overtemp_fault, overload_fault, supply_low_fault};
  wire [two_wire_pkg::FAULT_BITS-1:0] fault_now = fault_s;
  wire [7:0] status_byte = {stat_live, faults | fault_now};
  wire ctrl_take = scl_fall & byte_in & state == two_wire_pkg::st_data;

  assign bus.dev_sda_o = 1'b0;
  assign bus.dev_irq_o = 1'b0;
  assign bus.dev_sda_oe = sda_oe;
  assign bus.dev_irq_oe = irq_oe;

  // The clock is sampled, never driven.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      scl_meta <= 1'b1;
      scl_s <= 1'b1;
      scl_p <= 1'b1;
      sda_meta <= 1'b1;
      sda_s <= 1'b1;
      sda_p <= 1'b1;
      sel_meta <= 2'h0;
      sel_s <= 2'h0;
    end else begin
      scl_meta <= bus.scl;
      scl_s <= scl_meta;
      scl_p <= scl_s;
      sda_meta <= bus.sda;
      sda_s <= sda_meta;
      sda_p <= sda_s;
      sel_meta <= addr_sel;
      sel_s <= sel_meta;
    end
  end

  // A fault shorter than one cycle may be missed; detectors hold their flags longer.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      fault_meta <= '0;
      fault_s <= '0;
    end else begin
      fault_meta <= fault_pins;
      fault_s <= fault_meta;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state <= two_wire_pkg::st_idle;
      bit_cnt <= 4'h0;
      shift <= 8'h0;
      tx <= 8'h0;
      acked <= 1'b0;
      sda_oe <= 1'b0;
    end else if (start_seen | stop_seen) begin
      // A stray condition always wins, even mid-byte or mid-acknowledge.
      state <= start_seen ? two_wire_pkg::st_chip : two_wire_pkg::st_idle;
      bit_cnt <= 4'h0;
      sda_oe <= 1'b0;
    end else if (scl_rise) begin
      if (bit_cnt < two_wire_pkg::BITS_PER_BYTE) begin
        shift <= shift_in(shift, sda_s);
        tx <= shift_in(tx, 1'b0);
      end
      if (state != two_wire_pkg::st_idle) begin
        bit_cnt <= bit_cnt + two_wire_pkg::BIT_STEP;
      end
    end else if (scl_fall) begin
      if (byte_in) begin
        // In send the line is let go so the master can answer.
        sda_oe <= want_ack & !in_send;
        acked <= want_ack;
      end else if (ack_end) begin
        bit_cnt <= 4'h0;
        sda_oe <= 1'b0;
        case (state)
          two_wire_pkg::st_chip: begin
            if (!acked) begin
              state <= two_wire_pkg::st_ignore;
            end else if (shift[0]) begin
              state <= two_wire_pkg::st_send;
              tx <= status_byte;
              sda_oe <= pull_for(status_byte[7]);
            end else begin
              state <= two_wire_pkg::st_reg;
            end
          end
          two_wire_pkg::st_reg: begin
            state <= acked ? two_wire_pkg::st_data : two_wire_pkg::st_ignore;
          end
          two_wire_pkg::st_idle: begin
            // Clocks seen before any start leave the slave idle and its bit count at zero.
            state <= two_wire_pkg::st_idle;
          end
          default: state <= two_wire_pkg::st_ignore;
        endcase
      end else if (in_send) begin
        sda_oe <= pull_for(tx[7]);
      end
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      control_settings <= two_wire_pkg::CTRL_RESET;
      ctrl_written <= 1'b0;
    end else begin
      // The pulse lines up with the new value so users act on it exactly once.
      ctrl_written <= ctrl_take;
      if (ctrl_take) begin
        control_settings <= shift;
      end
    end
  end

  // A fault in the acknowledge cycle stays latched for the next read.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      faults <= '0;
      irq_oe <= 1'b0;
    end else begin
      faults <= (master_ack ? '0 : faults) | fault_now;
      irq_oe <= (irq_oe & !master_ack) | (|fault_now);
    end
  end
endmodule : serial_two_wire_register_slave

// ===== sim/two_wire_checker.sv
// Link checker for the two-wire master and register slave.
`timescale 1ns/1ps
module two_wire_checker (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic scl,
  input wire logic sda,
  input wire logic host_scl_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic dev_irq_o,
  input wire logic [1:0] addr_sel
);
  logic scl_q;
  logic sda_q;
  logic rd;
  logic [6:0] n;
  logic [7:0] sh;
  wire logic rise;
  wire logic frame;
  wire logic [6:0] own;
  assign rise = scl && !scl_q;
  assign frame = scl && scl_q && (sda != sda_q);
  assign own = {two_wire_pkg::CHIP_PREFIX, addr_sel};
  // Start and stop both clear the bit count, so byte positions follow the slave's view.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      rd <= 1'b0;
      n <= 7'h0;
      sh <= 8'h0;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      n <= frame ? 7'h0 : (rise ? n + 7'h1 : n);
      sh <= rise ? {sh[6:0], sda} : sh;
      rd <= (rise && n == 7'h8) ? sh[0] : rd;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  property p_open_drain; !dev_sda_o && !dev_irq_o; endproperty
  property p_clock_master; scl == !host_scl_oe; endproperty
  property p_data_low; $changed(dev_sda_oe) |-> !scl; endproperty
  property p_quiet_byte; dev_sda_oe |-> n >= 7'h8; endproperty
  property p_ack_own; rise && n == 7'h8 && sh[7:1] == own |-> !sda; endproperty
  property p_nack_foreign; rise && n == 7'h8 && sh[7:1] != own |-> !dev_sda_oe; endproperty
  property p_nack_reg; rise && n == 7'h11 && !rd && sh != 8'h00 |-> !dev_sda_oe; endproperty
  property p_release_status; rise && n == 7'h11 && rd |-> !dev_sda_oe; endproperty
  property p_host_ack; rise && n == 7'h11 && rd |-> !sda; endproperty
  a_open_drain: assert property (p_open_drain) else $error("slave drove high");
  a_clock_master: assert property (p_clock_master) else $error("clock not master");
  a_data_low: assert property (p_data_low) else $error("data moved in clock high");
  a_quiet_byte: assert property (p_quiet_byte) else $error("drive in first byte");
  a_ack_own: assert property (p_ack_own) else $error("own address not acked");
  a_nack_foreign: assert property (p_nack_foreign) else $error("foreign acked");
  a_nack_reg: assert property (p_nack_reg) else $error("bad register acked");
  a_release_status: assert property (p_release_status) else $error("no release");
  a_host_ack: assert property (p_host_ack) else $error("status not acked");
  c_data_ack: cover property (rise && n == 7'h1a && !sda);
  c_status: cover property (rise && n == 7'h11 && rd);
  c_frame: cover property (frame);
endmodule : two_wire_checker

// ===== sim/testbench.sv
// Self-checking bench joining the bus master and the register slave.
`timescale 1ns/1ps
module testbench;
  logic ref_clk;
  logic reset;
  logic [1:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [1:0] addr_sel;
  logic [2:0] fault_in;
  logic [4:0] stat_live;
  logic [7:0] control_settings;
  logic ctrl_written;
  logic [31:0] rdv;
  int fails;
  int comparisons;
  int pulses;
  two_wire_if two_wire_if_inst ();
  two_wire_bus_master #(.QTR_CYCLES(8)) two_wire_bus_master_inst (
    .ref_clk(ref_clk), .reset(reset), .bus(two_wire_if_inst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  serial_two_wire_register_slave serial_two_wire_register_slave_inst (
    .ref_clk(ref_clk), .reset(reset), .bus(two_wire_if_inst), .addr_sel(addr_sel),
    .supply_low_fault(fault_in[0]), .overload_fault(fault_in[1]),
    .overtemp_fault(fault_in[2]), .stat_live(stat_live),
    .control_settings(control_settings), .ctrl_written(ctrl_written));
  two_wire_checker two_wire_checker_inst (
    .ref_clk(ref_clk), .reset(reset), .scl(two_wire_if_inst.scl), .sda(two_wire_if_inst.sda),
    .host_scl_oe(two_wire_if_inst.host_scl_oe), .dev_sda_o(two_wire_if_inst.dev_sda_o),
    .dev_sda_oe(two_wire_if_inst.dev_sda_oe), .dev_irq_o(two_wire_if_inst.dev_irq_o),
    .addr_sel(addr_sel));
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) if (ctrl_written === 1'b1) pulses++;
  task report_and_stop;
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  task check(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check
  // The request stays put until the edge that samples waitrequest low.
  task av(input logic [1:0] a, input logic [31:0] d, input logic wr);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    rdv = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge ref_clk);
  endtask : av
  task xfer(input logic [1:0] sel, input logic rd);
    int k;
    av(two_wire_pkg::OFS_CMD, {22'h0, rd, !rd, 6'h0, sel}, 1'b1);
    k = 0;
    do begin
      av(two_wire_pkg::OFS_STAT, 32'h0, 1'b0);
      k++;
    end while (rdv[0] !== 1'b0 && k < 4000);
    check({31'h0, k < 4000}, 32'h1, "transfer end");
  endtask : xfer
  task nack_is(input logic e);
    av(two_wire_pkg::OFS_STAT, 32'h0, 1'b0);
    check({31'h0, rdv[1]}, {31'h0, e}, "nack flag");
  endtask : nack_is
  task write_ctrl(input logic [1:0] sel, input logic [7:0] d, input logic [7:0] exp, int np);
    int p;
    av(two_wire_pkg::OFS_WDATA, {24'h0, d}, 1'b1);
    p = pulses;
    xfer(sel, 1'b0);
    check({24'h0, control_settings}, {24'h0, exp}, "control value");
    check(32'(pulses - p), 32'(np), "update pulses");
  endtask : write_ctrl
  task t_write_all;
    logic [7:0] pat [4] = '{8'hff, 8'h00, 8'ha5, 8'h5a};
    for (int s = 0; s < 4; s++) begin
      addr_sel <= 2'(s);
      repeat (4) @(posedge ref_clk);
      write_ctrl(2'(s), pat[s], pat[s], 1);
      nack_is(1'b0);
    end
  endtask : t_write_all
  task t_foreign;
    addr_sel <= 2'h1;
    repeat (4) @(posedge ref_clk);
    write_ctrl(2'h2, 8'h3c, 8'h5a, 0);
    nack_is(1'b1);
    av(two_wire_pkg::OFS_STAT, 32'h2, 1'b1);
    nack_is(1'b0);
  endtask : t_foreign
  task t_status;
    stat_live <= 5'h15;
    for (int i = 0; i < 3; i++) begin
      fault_in <= 3'h1 << i;
      @(posedge ref_clk);
      fault_in <= 3'h0;
      repeat (4) @(posedge ref_clk);
      check({31'h0, two_wire_if_inst.irq_n}, 32'h0, "irq set");
      xfer(addr_sel, 1'b1);
      av(two_wire_pkg::OFS_RDATA, 32'h0, 1'b0);
      check(rdv, {24'h0, 5'h15, 3'(1 << i)}, "latched status");
      check({31'h0, two_wire_if_inst.irq_n}, 32'h1, "irq clear");
      nack_is(1'b0);
      xfer(addr_sel, 1'b1);
      av(two_wire_pkg::OFS_RDATA, 32'h0, 1'b0);
      check(rdv, {24'h0, 5'h15, 3'h0}, "released status");
    end
  endtask : t_status
  // A reset in mid-frame must leave both ends ready for a clean frame.
  task t_midreset;
    av(two_wire_pkg::OFS_WDATA, 32'h77, 1'b1);
    av(two_wire_pkg::OFS_CMD, {22'h0, 2'b01, 6'h0, addr_sel}, 1'b1);
    repeat (300) @(posedge ref_clk);
    reset <= 1'b1;
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (4) @(posedge ref_clk);
    check({21'h0, control_settings, two_wire_if_inst.scl, two_wire_if_inst.sda,
      two_wire_if_inst.irq_n}, 32'h7, "idle after reset");
    write_ctrl(addr_sel, 8'h96, 8'h96, 1);
  endtask : t_midreset
  initial begin
    #400000;
    fails++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    report_and_stop;
  end
  initial begin
    reset = 1'b1;
    avs_address = 2'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    addr_sel = 2'h0;
    fault_in = 3'h0;
    stat_live = 5'h0;
    fails = 0;
    comparisons = 0;
    pulses = 0;
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (4) @(posedge ref_clk);
    check({29'h0, two_wire_if_inst.scl, two_wire_if_inst.sda, two_wire_if_inst.irq_n},
      32'h7, "idle lines");
    t_write_all;
    t_foreign;
    t_status;
    t_midreset;
    report_and_stop;
  end
endmodule : testbench
